// >>> hdl/hpas_top.sv
// Hot-plug watcher for three output ports driving one source hot-plug line.
// Assumes hot-plug, enable and serial pins are asynchronous to clk.
// Overview of operation
// RQ1: A low hot-plug pulse up to the interrupt window is an interrupt only.
// RQ2: Active port low beyond the window is committed after the long delay.
// RQ3: A port change forces the source line deasserted for the switch time.
// RQ4: A newly asserted port is passed on only after the switch time.
// RQ5: Window and switch timers are reprogrammable by configuration bits.
// RQ6: All channels of a port move together through one port select.
// RQ7: An active port falling edge reaches the source line within microseconds.
// RQ8: In manual mode a new port's level shows within microseconds; without the pulse-disable bit it shows after the switch time.
// RQ9: Outputs wake 250 us after enable goes low; shut down while high.
// RQ10: Slave address is 1011, two strap bits, 1, then direction.
// RQ11: Reads give data bytes until the host does not acknowledge.
// RQ12: Writes use the slave address with direction bit zero.
// RQ13: Bytes are read and written at an index given in the transfer.
// RQ14: Address acknowledged only on full match; otherwise stay released.
// RQ15: First written byte is the index, later bytes stored there, all acked.
// RQ16: Select field 11 picks ports automatically by the priority field.
// RQ17: Polarity bit 0 passes the level, 1 inverts it.
// RQ18: Pulse-disable bit makes manual switches immediate.
// RQ19: Interrupt window is 2 ms or 4 ms by its configuration bit.
`include "hpas_defines.svh"
`default_nettype none
module hpas_top import hpas_pkg::*; #(
	parameter int T1_CYC = `HPAS_T1_MS * `HPAS_CLK_KHZ,
	parameter int T1L_CYC = `HPAS_T1L_MS * `HPAS_CLK_KHZ,
	parameter int T2_CYC = `HPAS_T2_MS * `HPAS_CLK_KHZ,
	parameter int T3_CYC = `HPAS_T3_MS * `HPAS_CLK_KHZ,
	parameter int WAKE_CYC = (`HPAS_WAKE_US * `HPAS_CLK_KHZ + 999) / 1000,
	// Arbitrary identification byte
	parameter logic [7:0] DEV_ID = 8'h5a
) (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Chip enable pin
	input wire logic chip_enable_n,
	// Hot-plug pins
	input wire logic [2:0] port_hotplug_in,
	output logic source_hotplug_out,
	// Port routing and status
	output logic [2:0] port_select,
	output logic chip_active,
	// Serial configuration port
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic addr_strap_hi,
	input wire logic addr_strap_lo
);
	localparam int CW = 26;

	hpas_state_type st_r, st_nxt;
	logic [1:0] sel_r, sel_nxt;
	logic [CW-1:0] cnt_r;
	logic cnt_clr;
	logic [CW-1:0] low_r [3];
	logic [2:0] hpd_s1, hpd_s2;
	logic en_s1, en_n_s2;
	logic [7:0] cfg0_r, cfg1_r, cfg2_r, cfg4_r;
	hpas_wr_type wr;
	logic [7:0] rd_idx, rd_data;

	function automatic logic [1:0] pick(input logic [2:0] pri,
		input logic [2:0] ok, input logic [1:0] cur);
		logic [5:0] ord;
		ord = 6'h00;
		case (pri)
			3'h0: ord = {2'h0, 2'h1, 2'h2};
			3'h1: ord = {2'h0, 2'h2, 2'h1};
			3'h2: ord = {2'h1, 2'h0, 2'h2};
			3'h3: ord = {2'h1, 2'h2, 2'h0};
			default: ord = pri[0] ? {2'h2, 2'h1, 2'h0} : {2'h2, 2'h0, 2'h1};
		endcase
		if (ok[ord[5:4]]) pick = ord[5:4];
		else if (ok[ord[3:2]]) pick = ord[3:2];
		else if (ok[ord[1:0]]) pick = ord[1:0];
		else pick = cur;
	endfunction

	function automatic logic [2:0] onehot(input logic [1:0] p);
		onehot = 3'(3'h1 << p);
	endfunction

	// RQ5 RQ19 timer selection
	wire [CW-1:0] t1lim = cfg1_r[`HPAS_T1_BIT] ? CW'(T1L_CYC) : CW'(T1_CYC);
	wire [CW-1:0] t2lim = cfg4_r[`HPAS_T2_BIT] ? CW'(T2_CYC / 2) : CW'(T2_CYC);
	wire [CW-1:0] t3lim = cfg1_r[`HPAS_T3_BIT] ? CW'(T3_CYC / 2) : CW'(T3_CYC);
	wire [CW-1:0] t4lim = cfg1_r[`HPAS_T4_BIT] ? CW'(T3_CYC / 2) : CW'(T3_CYC);
	wire pol_bit = cfg4_r[`HPAS_POL_BIT];
	wire nopulse = cfg4_r[`HPAS_NOPULSE_BIT];
	wire [1:0] sel_fld = cfg0_r[`HPAS_SEL_MSB:`HPAS_SEL_LSB];
	wire [2:0] pri_fld = cfg0_r[`HPAS_PRI_MSB:`HPAS_PRI_LSB];
	wire auto_mode = sel_fld == `HPAS_SEL_AUTO;
	wire lvl = hpd_s2[sel_r];
	wire [CW-1:0] act_low = low_r[sel_r];
	// RQ1 short lows still count as present
	wire [2:0] p_ok = hpd_s2 | {low_r[2] < t1lim, low_r[1] < t1lim,
		low_r[0] < t1lim};
	wire holding = st_r == ST_LIVE || st_r == ST_DISC;
	wire [2:0] ok_hold = p_ok | (holding ? onehot(sel_r) : 3'h0);
	// RQ16 automatic choice by priority
	wire [1:0] tgt = auto_mode ? pick(pri_fld, ok_hold, sel_r) : sel_fld;
	wire [1:0] tgt_free = auto_mode ? pick(pri_fld, p_ok, sel_r) : sel_fld;
	wire [7:0] wdata = wr.data;
	wire wr0 = wr.stb && wr.idx == `HPAS_REG_CFG0;
	wire wr1 = wr.stb && wr.idx == `HPAS_REG_CFG1;
	wire wr2 = wr.stb && wr.idx == `HPAS_REG_CFG2;
	wire wr4 = wr.stb && wr.idx == `HPAS_REG_CFG4;

	// RQ13 indexed read decode
	assign rd_data = (rd_idx == `HPAS_REG_CFG0) ? cfg0_r :
		(rd_idx == `HPAS_REG_CFG1) ? cfg1_r :
		(rd_idx == `HPAS_REG_CFG2) ? cfg2_r :
		(rd_idx == `HPAS_REG_ID) ? DEV_ID :
		(rd_idx == `HPAS_REG_CFG4) ? {cfg4_r[7:4], hpd_s2, 1'b0} : 8'h00;

	always_comb begin
		st_nxt = st_r;
		sel_nxt = sel_r;
		cnt_clr = 1'b0;
		case (st_r)
			ST_SHUT: if (!en_n_s2) begin
				st_nxt = ST_WAKE;
				cnt_clr = 1'b1;
			end
			// RQ9 wake-up time
			ST_WAKE: if (cnt_r >= CW'(WAKE_CYC - 1)) begin
				st_nxt = ST_ARM;
				sel_nxt = tgt;
				cnt_clr = 1'b1;
			end
			ST_LIVE: if (tgt != sel_r) begin
				// RQ18 RQ3 immediate or pulsed switch
				sel_nxt = tgt;
				cnt_clr = 1'b1;
				st_nxt = (!auto_mode && nopulse) ? ST_LIVE : ST_SWITCH;
			end else if (act_low >= t1lim && !lvl) begin
				// RQ1 still low after the full window is a disconnect
				st_nxt = ST_DISC;
				cnt_clr = 1'b1;
			end
			ST_DISC: if (lvl) begin
				st_nxt = ST_ARM;
				cnt_clr = 1'b1;
			end else if (cnt_r >= t2lim) begin
				// RQ2 commit the disconnect after the long delay
				cnt_clr = 1'b1;
				sel_nxt = tgt_free;
				st_nxt = (tgt_free != sel_r) ? ST_SWITCH : ST_ARM;
			end
			ST_SWITCH: if (cnt_r >= t3lim) begin
				st_nxt = ST_LIVE;
			end
			ST_ARM: if (tgt != sel_r) begin
				sel_nxt = tgt;
				cnt_clr = 1'b1;
				st_nxt = (!auto_mode && nopulse) ? ST_ARM : ST_SWITCH;
			end else if (!lvl) begin
				cnt_clr = 1'b1;
			end else if (cnt_r >= t4lim) begin
				// RQ4 assertion passed on after the delay
				st_nxt = ST_LIVE;
			end
			default: st_nxt = ST_SHUT;
		endcase
		if (en_n_s2) begin
			st_nxt = ST_SHUT;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hpd_s1 <= 3'h0;
			hpd_s2 <= 3'h0;
			en_s1 <= 1'b1;
			en_n_s2 <= 1'b1;
			st_r <= ST_SHUT;
			sel_r <= 2'h0;
			cnt_r <= '0;
			for (int i = 0; i < 3; i++) low_r[i] <= '0;
		end else if (ce) begin
			hpd_s1 <= port_hotplug_in;
			hpd_s2 <= hpd_s1;
			en_s1 <= chip_enable_n;
			en_n_s2 <= en_s1;
			st_r <= st_nxt;
			sel_r <= sel_nxt;
			cnt_r <= cnt_clr ? '0 : (&cnt_r ? cnt_r : CW'(cnt_r + 1'b1));
			for (int i = 0; i < 3; i++) begin
				low_r[i] <= hpd_s2[i] ? '0 :
					(low_r[i] >= t1lim ? low_r[i] : CW'(low_r[i] + 1'b1));
			end
		end
	end

	// RQ7 RQ8 RQ17 RQ6 outputs from the next state
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			source_hotplug_out <= 1'b0;
			port_select <= 3'h0;
			chip_active <= 1'b0;
			sda_out <= 1'b0;
		end else if (ce) begin
			source_hotplug_out <= (st_nxt == ST_LIVE ? hpd_s2[sel_nxt] : 1'b0)
				^ pol_bit;
			chip_active <= st_nxt != ST_SHUT && st_nxt != ST_WAKE;
			port_select <= (st_nxt == ST_SHUT || st_nxt == ST_WAKE) ? 3'h0 :
				onehot(sel_nxt);
			sda_out <= 1'b0;
		end
	end

	// RQ5 configuration bytes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg0_r <= `HPAS_CFG0_RST;
			cfg1_r <= `HPAS_CFG1_RST;
			cfg2_r <= `HPAS_CFG2_RST;
			cfg4_r <= `HPAS_CFG4_RST;
		end else if (ce) begin
			if (wr0) cfg0_r <= wdata & `HPAS_CFG0_WMASK;
			if (wr1) cfg1_r <= wdata;
			if (wr2) cfg2_r <= wdata;
			if (wr4) cfg4_r <= wdata & `HPAS_CFG4_WMASK;
		end
	end

	hpas_i2c u_i2c (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe(sda_oe),
		.addr_strap_hi(addr_strap_hi),
		.addr_strap_lo(addr_strap_lo),
		.wr(wr),
		.rd_idx(rd_idx),
		.rd_data(rd_data)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_live_steady;
		ce && !en_n_s2 && st_r == ST_LIVE && tgt == sel_r;
	endsequence

	a_follow_fall: assert property ( // RQ7
		(s_live_steady and !lvl) |=> source_hotplug_out == $past(pol_bit))
		else $error("source line did not follow active port low");
	a_polarity_map: assert property ( // RQ17
		(s_live_steady and (act_low < t1lim))
		|=> source_hotplug_out == ($past(lvl) ^ $past(pol_bit)))
		else $error("source line level or polarity wrong");
	a_irq_window: assert property ( // RQ1
		(ce && st_r == ST_LIVE ##1 st_r == ST_DISC)
		|-> $past(act_low) >= $past(t1lim))
		else $error("disconnect declared inside interrupt window");
	a_disc_delay: assert property ( // RQ2
		(ce && st_r == ST_DISC && !lvl && !en_n_s2 ##1 st_r != ST_DISC)
		|-> $past(cnt_r) >= $past(t2lim))
		else $error("disconnect committed before its delay");
	a_switch_low: assert property ( // RQ3
		(st_r == ST_SWITCH) [*2] |-> source_hotplug_out == $past(pol_bit))
		else $error("source line not held off during switchover");
	a_switch_time: assert property ( // RQ3
		(st_r == ST_SWITCH ##1 st_r == ST_LIVE)
		|-> $past(cnt_r) >= $past(t3lim))
		else $error("switchover period too short");
	a_assert_delay: assert property ( // RQ4
		(st_r == ST_ARM ##1 st_r == ST_LIVE) |-> $past(cnt_r) >= $past(t4lim))
		else $error("port assertion passed on too early");
	a_manual_fast: assert property ( // RQ18
		(ce && !en_n_s2 && st_r == ST_LIVE && !auto_mode && nopulse &&
		tgt != sel_r) |=> st_r == ST_LIVE && sel_r == $past(tgt))
		else $error("manual switch not immediate");
	a_shut_hold: assert property ( // RQ9
		(ce && en_n_s2) |=> st_r == ST_SHUT && !chip_active &&
		port_select == 3'h0)
		else $error("device active while disabled");
	a_wake_time: assert property ( // RQ9
		$rose(chip_active) |-> $past(cnt_r) >= CW'(WAKE_CYC - 1))
		else $error("outputs enabled before wake-up time");
	a_one_port: assert property ( // RQ6
		chip_active |-> $onehot(port_select))
		else $error("port select not a single port");
endmodule // hpas_top
`default_nettype wire

// >>> hdl/hpas_defines.svh
// Constants for the hot-plug port auto-select block.
// Assumes a 20 MHz system clock; all times are turned into cycles by users.
`ifndef HPAS_DEFINES_SVH
`define HPAS_DEFINES_SVH

// Clock rate and documented times
`define HPAS_CLK_KHZ 20000
`define HPAS_T1_MS 2
`define HPAS_T1L_MS 4
`define HPAS_T2_MS 2000
`define HPAS_T3_MS 1000
`define HPAS_WAKE_US 250

// Register indexes
`define HPAS_REG_CFG0 8'h00
`define HPAS_REG_CFG1 8'h01
`define HPAS_REG_CFG2 8'h02
`define HPAS_REG_ID 8'h03
`define HPAS_REG_CFG4 8'h04

// Reset values and write masks
`define HPAS_CFG0_RST 8'h01
`define HPAS_CFG1_RST 8'h00
`define HPAS_CFG2_RST 8'h00
`define HPAS_CFG4_RST 8'h00
`define HPAS_CFG0_WMASK 8'h7f
`define HPAS_CFG4_WMASK 8'hf8

// Field positions
`define HPAS_SEL_MSB 6
`define HPAS_SEL_LSB 5
`define HPAS_PRI_MSB 4
`define HPAS_PRI_LSB 2
`define HPAS_T1_BIT 0
`define HPAS_T4_BIT 1
`define HPAS_T3_BIT 2
`define HPAS_T2_BIT 3
`define HPAS_NOPULSE_BIT 5
`define HPAS_POL_BIT 7
`define HPAS_SEL_AUTO 2'h3

// Serial slave address: fixed high nibble and fixed bit 1
`define HPAS_ADDR_FIXED_HI 4'hb
`define HPAS_ADDR_FIXED_LO 1'h1

`endif

// >>> hdl/hpas_pkg.sv
// Types shared by the hot-plug auto-select top and its serial slave.
// Assumes the constants header is included by the users.
`default_nettype none
package hpas_pkg;

	typedef enum logic [5:0] {
		ST_SHUT = 6'h01,
		ST_WAKE = 6'h02,
		ST_ARM = 6'h04,
		ST_LIVE = 6'h08,
		ST_DISC = 6'h10,
		ST_SWITCH = 6'h20
	} hpas_state_type;

	typedef enum logic [7:0] {
		I_IDLE = 8'h01,
		I_ADDR = 8'h02,
		I_ACKA = 8'h04,
		I_WIDX = 8'h08,
		I_ACKW = 8'h10,
		I_WDAT = 8'h20,
		I_RDAT = 8'h40,
		I_RACK = 8'h80
	} hpas_i2c_state_type;

	typedef struct packed {
		logic stb;
		logic [7:0] idx;
		logic [7:0] data;
	} hpas_wr_type;

endpackage
`default_nettype wire

// >>> hdl/hpas_i2c.sv
// Byte-wide serial slave giving indexed access to the configuration bytes.
// Assumes open-drain pins and straps arrive asynchronously; syncs them here.
`include "hpas_defines.svh"
`default_nettype none
module hpas_i2c import hpas_pkg::*; (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Serial pins and address straps
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe,
	input wire logic addr_strap_hi,
	input wire logic addr_strap_lo,
	// Register access
	output hpas_wr_type wr,
	output logic [7:0] rd_idx,
	input wire logic [7:0] rd_data
);
	logic [3:0] s1_r, s2_r, s3_r;
	hpas_i2c_state_type st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r, tx_r;
	logic rw_r, nack_r;

	wire scl = s2_r[3];
	wire sda = s2_r[2];
	wire scl_rise = scl && !s3_r[3];
	wire scl_fall = !scl && s3_r[3];
	wire start_c = scl && s3_r[3] && s3_r[2] && !sda;
	wire stop_c = scl && s3_r[3] && !s3_r[2] && sda;
	wire byte_done = bit_r == 4'h8;
	// RQ10 address layout
	wire match = sh_r[7:1] == {`HPAS_ADDR_FIXED_HI, s2_r[1], s2_r[0],
		`HPAS_ADDR_FIXED_LO};

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_r <= 4'h0;
			s2_r <= 4'h0;
			s3_r <= 4'h0;
			st_r <= I_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			rw_r <= 1'b0;
			nack_r <= 1'b1;
			sda_oe <= 1'b0;
			wr <= '0;
			rd_idx <= 8'h00;
		end else if (ce) begin
			s1_r <= {scl_in, sda_in, addr_strap_hi, addr_strap_lo};
			s2_r <= s1_r;
			s3_r <= s2_r;
			wr.stb <= 1'b0;
			if (start_c) begin
				st_r <= I_ADDR;
				bit_r <= 4'h0;
				sda_oe <= 1'b0;
			end else if (stop_c) begin
				st_r <= I_IDLE;
				sda_oe <= 1'b0;
			end else if (scl_rise) begin
				sh_r <= {sh_r[6:0], sda};
				nack_r <= sda;
				bit_r <= 4'(bit_r + 4'h1);
			end else if (scl_fall) begin
				case (st_r)
					I_ADDR: if (byte_done) begin
						// RQ14 ack only on match
						if (match) begin
							sda_oe <= 1'b1;
							rw_r <= sh_r[0];
							st_r <= I_ACKA;
						end else begin
							st_r <= I_IDLE;
						end
					end
					// RQ11 read data follows the address ack
					I_ACKA: if (rw_r) begin
						tx_r <= rd_data;
						sda_oe <= !rd_data[7];
						st_r <= I_RDAT;
						bit_r <= 4'h0;
					end else begin
						// RQ12 write transfer goes on to the index
						sda_oe <= 1'b0;
						st_r <= I_WIDX;
						bit_r <= 4'h0;
					end
					I_WIDX, I_WDAT: if (byte_done) begin
						// RQ15 index first, then data at that index
						sda_oe <= 1'b1;
						st_r <= I_ACKW;
						if (st_r == I_WIDX) begin
							rd_idx <= sh_r;
						end else begin
							wr.stb <= 1'b1;
							wr.idx <= rd_idx;
							wr.data <= sh_r;
						end
					end
					I_ACKW: begin
						sda_oe <= 1'b0;
						st_r <= I_WDAT;
						bit_r <= 4'h0;
					end
					I_RDAT: if (byte_done) begin
						sda_oe <= 1'b0;
						st_r <= I_RACK;
					end else begin
						tx_r <= {tx_r[6:0], 1'b0};
						sda_oe <= !tx_r[6];
					end
					I_RACK: if (!nack_r) begin
						tx_r <= rd_data;
						sda_oe <= !rd_data[7];
						st_r <= I_RDAT;
						bit_r <= 4'h0;
					end else begin
						st_r <= I_IDLE;
					end
					default: ;
				endcase
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_addr_nomatch: assert property ( // RQ14
		(ce && scl_fall && st_r == I_ADDR && byte_done && !match)
		|=> !sda_oe [*2])
		else $error("address mismatch was acknowledged");
	a_write_ack: assert property ( // RQ15
		(ce && scl_fall && st_r == I_WDAT && byte_done)
		|=> sda_oe && wr.stb && wr.data == $past(sh_r))
		else $error("data byte not stored or not acknowledged");
endmodule // hpas_i2c
`default_nettype wire

// >>> verification/hpas_host_model.sv
// Serial configuration host for the hot-plug auto-select bench.
// Assumes the bench resolves sda as open drain with a pull-up.
`default_nettype none
module hpas_host_model (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic scl,
	output logic sda_drv,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 1ns;

	// Bus idles released; scl stands high between frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Start, also usable as repeated start from scl low
	task automatic start();
		sda_drv = 1'b1;
		wait_clk(2);
		scl = 1'b1;
		wait_clk(2);
		sda_drv = 1'b0;
		wait_clk(2);
		scl = 1'b0;
	endtask

	task automatic stop();
		wait_clk(2);
		sda_drv = 1'b0;
		wait_clk(2);
		scl = 1'b1;
		wait_clk(2);
		sda_drv = 1'b1;
		wait_clk(4);
	endtask

	// One bit in 400 ns: data mid-low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		wait_clk(2);
		sda_drv = b;
		wait_clk(2);
		scl = 1'b1;
		wait_clk(2);
		r = sda;
		wait_clk(2);
		scl = 1'b0;
	endtask

	task automatic byte_io(input logic [7:0] d, input logic ack_in,
		output logic [7:0] r, output logic ack_out);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(ack_in, ack_out);
	endtask

	// write: address, index, optional data byte
	task automatic wr(input logic [7:0] adr, input logic [7:0] idx,
		input logic [7:0] d, input bit n, output logic [2:0] ack);
		logic [7:0] r;
		logic a0, a1, a2;
		start();
		byte_io(adr, 1'b1, r, a0);
		byte_io(idx, 1'b1, r, a1);
		a2 = 1'b0;
		if (n)
			byte_io(d, 1'b1, r, a2);
		stop();
		ack = ~{a0, a1, a2};
	endtask

	// read: address, acked byte, unacked last byte
	task automatic rd(input logic [7:0] adr, output logic [7:0] d0,
		output logic [7:0] d1);
		logic a;
		start();
		byte_io(adr, 1'b1, d0, a);
		byte_io(8'hff, 1'b0, d0, a);
		byte_io(8'hff, 1'b1, d1, a);
		stop();
	endtask
endmodule // hpas_host_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the hot-plug auto-select top.
// Assumes shortened timer parameters and the serial host model.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	// Arbitrary identification value
	localparam logic [7:0] ID_VAL = 8'h3c;
	localparam logic [7:0] WA = 8'hba;
	localparam logic [7:0] RA = 8'hbb;
	logic clk, sys_rst, ce, chip_enable_n, addr_strap_hi, addr_strap_lo;
	logic [2:0] port_hotplug_in, port_select, ack;
	logic source_hotplug_out, chip_active, sda_out, sda_oe, scl, sda_drv;
	wire logic sda;
	int miscompares = 0;
	int check_count = 0;
	int k;
	logic [31:0] lfsr_q = 32'hbbe4cd5e;
	logic [7:0] d0, d1, v;
	logic [7:0] idx_t[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h10};
	logic [7:0] exp_t[6] = '{8'h01, 8'h00, 8'h00, ID_VAL, 8'h00, 8'h00};
	logic [7:0] bad_t[4] = '{8'haa, 8'hb2, 8'hbe, 8'hb8};

	assign sda = sda_drv & ~(sda_oe & ~sda_out);

	hpas_top #(.T1_CYC(20), .T1L_CYC(40), .T2_CYC(200), .T3_CYC(100),
		.WAKE_CYC(10), .DEV_ID(ID_VAL)) u_dut (.clk(clk), .sys_rst(sys_rst),
		.ce(ce), .chip_enable_n(chip_enable_n),
		.port_hotplug_in(port_hotplug_in),
		.source_hotplug_out(source_hotplug_out), .port_select(port_select),
		.chip_active(chip_active), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_hi(addr_strap_hi),
		.addr_strap_lo(addr_strap_lo));

	hpas_host_model u_host (.clk(clk), .scl(scl), .sda_drv(sda_drv),
		.sda(sda));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	function automatic void rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
	endfunction

	// First or second port of a priority code, one-hot
	function automatic logic [2:0] prio(input logic [2:0] p, input bit nxt);
		logic [5:0] t;
		t = p[2] ? (p[0] ? 6'h22 : 6'h21) :
			(p[1] ? (p[0] ? 6'h14 : 6'h11) : (p[0] ? 6'h0c : 6'h0a));
		return nxt ? t[2:0] : t[5:3];
	endfunction

	task automatic rdreg(input logic [7:0] i);
		u_host.wr(WA, i, 8'h00, 0, ack);
		u_host.rd(RA, d0, d1);
	endtask

	// Low pulse on port 0, then level seen 8 cycles after return
	task automatic pulse(input int n, input logic e);
		port_hotplug_in[0] = 1'b0;
		cyc(5);
		chk(8'(source_hotplug_out), 8'h00);
		cyc(n - 5);
		port_hotplug_in[0] = 1'b1;
		cyc(8);
		chk(8'(source_hotplug_out), 8'(e));
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		#3000000;
		miscompares++;
		end_sim();
	end

	initial begin
		sys_rst = 1'b1;
		ce = 1'b1;
		chip_enable_n = 1'b1;
		port_hotplug_in = 3'h0;
		addr_strap_hi = 1'b1;
		addr_strap_lo = 1'b0;
		cyc(16);
		sys_rst = 1'b0;
		cyc(30);
		chk(8'(chip_active), 8'h00);
		chk(8'(port_select), 8'h00);
		for (int i = 0; i < 6; i++) begin
			rdreg(idx_t[i]);
			chk(d0, exp_t[i]);
			chk(d1, exp_t[i]);
		end
		foreach (bad_t[i]) begin
			u_host.wr(bad_t[i], 8'h02, 8'hff, 1, ack);
			chk(8'(ack), 8'h00);
		end
		rdreg(8'h02);
		chk(d0, 8'h00);
		u_host.wr(WA, 8'h03, ~ID_VAL, 1, ack);
		u_host.rd(RA, d0, d1);
		chk(d0, ID_VAL);
		repeat (4) begin
			rnd();
			v = lfsr_q[7:0];
			u_host.wr(WA, 8'h02, v, 1, ack);
			chk(8'(ack), 8'h07);
			u_host.rd(RA, d0, d1);
			chk(d0, v);
			chk(d1, v);
		end
		$display("test registers done");
		chip_enable_n = 1'b0;
		k = 0;
		while (chip_active !== 1'b1 && k < 40) begin
			cyc(1);
			k++;
		end
		chk(8'(k >= 10 && k <= 16), 8'h01);
		port_hotplug_in = 3'h1;
		cyc(90);
		chk(8'(source_hotplug_out), 8'h00);
		cyc(20);
		chk(8'(source_hotplug_out), 8'h01);
		chk(8'(port_select), 8'h01);
		rdreg(8'h04);
		chk(d0, 8'h02);
		$display("test wake done");
		pulse(20, 1'b1);
		repeat (3) begin
			rnd();
			pulse(6 + int'(lfsr_q[3:0] % 12), 1'b1);
		end
		chk(8'(port_select), 8'h01);
		pulse(30, 1'b0);
		cyc(120);
		u_host.wr(WA, 8'h01, 8'h01, 1, ack);
		pulse(30, 1'b1);
		u_host.wr(WA, 8'h01, 8'h00, 1, ack);
		u_host.wr(WA, 8'h04, 8'h80, 1, ack);
		cyc(5);
		chk(8'(source_hotplug_out), 8'h00);
		u_host.wr(WA, 8'h04, 8'h00, 1, ack);
		$display("test pulses done");
		port_hotplug_in = 3'h3;
		// Halved switchover time from here on
		u_host.wr(WA, 8'h01, 8'h04, 1, ack);
		u_host.wr(WA, 8'h00, 8'h21, 1, ack);
		cyc(30);
		chk(8'(source_hotplug_out), 8'h00);
		cyc(40);
		chk(8'(source_hotplug_out), 8'h01);
		chk(8'(port_select), 8'h02);
		u_host.wr(WA, 8'h04, 8'h20, 1, ack);
		port_hotplug_in = 3'h7;
		u_host.wr(WA, 8'h00, 8'h41, 1, ack);
		cyc(2);
		chk(8'(source_hotplug_out), 8'h01);
		chk(8'(port_select), 8'h04);
		u_host.wr(WA, 8'h04, 8'h00, 1, ack);
		$display("test manual done");
		for (int p = 0; p < 8; p++) begin
			u_host.wr(WA, 8'h00, {3'b011, 3'(p), 2'b01}, 1, ack);
			cyc(260);
			chk(8'(port_select), 8'(prio(3'(p), 0)));
			chk(8'(source_hotplug_out), 8'h01);
		end
		port_hotplug_in = 3'h3;
		cyc(150);
		chk(8'(source_hotplug_out), 8'h00);
		chk(8'(port_select), 8'h04);
		cyc(250);
		chk(8'(port_select), 8'(prio(3'h7, 1)));
		chk(8'(source_hotplug_out), 8'h01);
		// Clock enable low freezes everything, synchronisers included
		ce = 1'b0;
		port_hotplug_in = 3'h0;
		cyc(40);
		chk(8'(source_hotplug_out), 8'h01);
		chk(8'(port_select), 8'h02);
		port_hotplug_in = 3'h3;
		ce = 1'b1;
		chip_enable_n = 1'b1;
		cyc(10);
		chk(8'(chip_active), 8'h00);
		chk(8'(port_select), 8'h00);
		$display("test auto done");
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
